// file: ged_pkg.sv
// package: register map, field widths and reset values for the gpio edge latch block
package ged_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  // printed offsets are not word multiples: they are register indices, byte address = index * 4
  localparam logic [ADDR_W-1:0] IDX_P0_RISE = 16'hA028;
  localparam logic [ADDR_W-1:0] IDX_P1_RISE = 16'hA029;
  localparam logic [ADDR_W-1:0] IDX_P0_FALL = 16'hA038;
  localparam logic [ADDR_W-1:0] IDX_P1_FALL = 16'hA039;
  // own control register indices: irq enables and pin assignment
  localparam logic [ADDR_W-1:0] IDX_IRQ_CTRL = 16'hA03A;
  localparam logic [ADDR_W-1:0] IDX_ASSIGN_A = 16'hA03B;
  localparam logic [ADDR_W-1:0] IDX_ASSIGN_B = 16'hA03C;
  localparam int unsigned IDX_SHIFT = 2;
  localparam logic [PORT_W-1:0] EDGE_RST = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;
  localparam int unsigned CTRL_P0_EN_BIT = 0;
  localparam int unsigned CTRL_P1_EN_BIT = 1;
endpackage

// file: ged_edge_if.sv
// interface: arm bits from the register file and flags back from one port's edge latches
`timescale 1ns/1ps
interface ged_edge_if #(parameter int unsigned W = 8);
  logic [W-1:0] riseArm;
  logic [W-1:0] fallArm;
  logic [W-1:0] riseClr;
  logic [W-1:0] fallClr;
  logic [W-1:0] riseFlag;
  logic [W-1:0] fallFlag;
  modport ctrl (output riseArm, output fallArm, output riseClr, output fallClr, input riseFlag, input fallFlag);
  modport port (input riseArm, input fallArm, input riseClr, input fallClr, output riseFlag, output fallFlag);
endinterface

// file: ged_port_latch.sv
// one port: pin synchroniser, edge compare and sticky rise/fall flags
`timescale 1ns/1ps
module ged_port_latch
  import ged_pkg::*;
#(
  parameter int unsigned W = PORT_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinIn,
  ged_edge_if.port          edge_io
);
  // sync1, sync2 and prev all need a real sample before a compare may count
  localparam int unsigned FILL_W = 3;

  typedef struct packed {
    logic [W-1:0]      sync1;
    logic [W-1:0]      sync2;
    logic [W-1:0]      prev;
    logic [FILL_W-1:0] fill;
    logic [W-1:0]      rise;
    logic [W-1:0]      fall;
  } ged_latch_t;

  ged_latch_t s_q;
  ged_latch_t s_d;
  logic [W-1:0] riseEv;
  logic [W-1:0] fallEv;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = pinIn;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    // a pin held high through reset is a level, not an edge
    s_d.fill = {s_q.fill[FILL_W-2:0], 1'b1};
    riseEv = s_q.sync2 & ~s_q.prev & {W{s_q.fill[FILL_W-1]}};
    fallEv = ~s_q.sync2 & s_q.prev & {W{s_q.fill[FILL_W-1]}};
    // set wins over a same-cycle clear
    s_d.rise = (s_q.rise & ~edge_io.riseClr) | (riseEv & edge_io.riseArm);
    s_d.fall = (s_q.fall & ~edge_io.fallClr) | (fallEv & edge_io.fallArm);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign edge_io.riseFlag = s_q.rise;
  assign edge_io.fallFlag = s_q.fall;
endmodule

// file: ged_edge_top.sv
// top: apb register file, two port edge latches, pin interrupt combine
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module ged_edge_top
  import ged_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W+1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [PORT_W-1:0] port0Pin,
  input  wire logic [PORT_W-1:0] port1Pin,
  output logic                   pin_irq_a,
  output logic                   pin_irq_b
);
  typedef struct packed {
    logic [PORT_W-1:0] p0_rise_arm;
    logic [PORT_W-1:0] p0_fall_arm;
    logic [PORT_W-1:0] p1_rise_arm;
    logic [PORT_W-1:0] p1_fall_arm;
    logic [1:0]        port_pin_irq_enable;
    logic [2*PORT_W-1:0] pin_to_irq_a_assign;
    logic [2*PORT_W-1:0] pin_to_irq_b_assign;
    logic [DATA_W-1:0] rdata;
    logic              ready;
    logic              err;
    logic              irqA;
    logic              irqB;
  } ged_regs_t;

  ged_regs_t r_q;
  ged_regs_t r_d;

  ged_edge_if #(.W(PORT_W)) p0If ();
  ged_edge_if #(.W(PORT_W)) p1If ();

  ged_port_latch #(.W(PORT_W)) u_port0 (
    .clk     (clk),
    .rst     (rst),
    .pinIn   (port0Pin),
    .edge_io (p0If)
  );

  ged_port_latch #(.W(PORT_W)) u_port1 (
    .clk     (clk),
    .rst     (rst),
    .pinIn   (port1Pin),
    .edge_io (p1If)
  );

  // bus phase decode
  logic                setupPh;
  logic                accessPh;
  logic                xferDone;
  logic                wrDone;

  // register decode
  logic [ADDR_W-1:0]   regIdx;
  logic                wordAligned;
  logic                hitP0Rise;
  logic                hitP0Fall;
  logic                hitP1Rise;
  logic                hitP1Fall;
  logic                hitIrqCtrl;
  logic                hitAssignA;
  logic                hitAssignB;
  logic                idxMapped;
  logic                refused;

  // write strobes, one per register
  logic                wrP0Rise;
  logic                wrP0Fall;
  logic                wrP1Rise;
  logic                wrP1Fall;
  logic                wrIrqCtrl;
  logic                wrAssignA;
  logic                wrAssignB;

  // write data slices
  logic [PORT_W-1:0]   wByte;
  logic [1:0]          wCtrl;
  logic [2*PORT_W-1:0] wAssign;

  // read path
  logic [DATA_W-1:0]   rdWord;

  // flag clears towards the port latches
  logic [PORT_W-1:0]   clrP0Rise;
  logic [PORT_W-1:0]   clrP0Fall;
  logic [PORT_W-1:0]   clrP1Rise;
  logic [PORT_W-1:0]   clrP1Fall;

  // interrupt combine
  logic [PORT_W-1:0]   evtP0;
  logic [PORT_W-1:0]   evtP1;
  logic [2*PORT_W-1:0] flagsAll;
  logic [2*PORT_W-1:0] portGate;
  logic [2*PORT_W-1:0] srcA;
  logic [2*PORT_W-1:0] srcB;
  logic                reqA;
  logic                reqB;

  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable;
  // pready is registered, so r_q.ready is exactly what the master samples at this edge
  assign xferDone = accessPh & r_q.ready;
  assign wrDone = xferDone & pwrite;

  assign regIdx = paddr[ADDR_W+1:IDX_SHIFT];
  assign wordAligned = (paddr[IDX_SHIFT-1:0] == 2'h0);
  assign hitP0Rise = wordAligned & (regIdx == IDX_P0_RISE);
  assign hitP0Fall = wordAligned & (regIdx == IDX_P0_FALL);
  assign hitP1Rise = wordAligned & (regIdx == IDX_P1_RISE);
  assign hitP1Fall = wordAligned & (regIdx == IDX_P1_FALL);
  assign hitIrqCtrl = wordAligned & (regIdx == IDX_IRQ_CTRL);
  assign hitAssignA = wordAligned & (regIdx == IDX_ASSIGN_A);
  assign hitAssignB = wordAligned & (regIdx == IDX_ASSIGN_B);
  assign idxMapped = hitP0Rise | hitP0Fall | hitP1Rise | hitP1Fall | hitIrqCtrl | hitAssignA | hitAssignB;
  // misaligned or unmapped: answered with an error and no side effect
  assign refused = ~idxMapped;

  // writes commit at the completing edge only, so an aborted setup changes nothing
  assign wrP0Rise = wrDone & hitP0Rise;
  assign wrP0Fall = wrDone & hitP0Fall;
  assign wrP1Rise = wrDone & hitP1Rise;
  assign wrP1Fall = wrDone & hitP1Fall;
  assign wrIrqCtrl = wrDone & hitIrqCtrl;
  assign wrAssignA = wrDone & hitAssignA;
  assign wrAssignB = wrDone & hitAssignB;

  assign wByte = pwdata[PORT_W-1:0];
  assign wCtrl = pwdata[CTRL_P1_EN_BIT:CTRL_P0_EN_BIT];
  assign wAssign = pwdata[2*PORT_W-1:0];

  // clearing needs the enable written to zero; a write of one leaves the flag alone
  assign clrP0Rise = wrP0Rise ? ~wByte : '0;
  assign clrP0Fall = wrP0Fall ? ~wByte : '0;
  assign clrP1Rise = wrP1Rise ? ~wByte : '0;
  assign clrP1Fall = wrP1Fall ? ~wByte : '0;

  assign p0If.riseArm = r_q.p0_rise_arm;
  assign p0If.fallArm = r_q.p0_fall_arm;
  assign p1If.riseArm = r_q.p1_rise_arm;
  assign p1If.fallArm = r_q.p1_fall_arm;
  assign p0If.riseClr = clrP0Rise;
  assign p0If.fallClr = clrP0Fall;
  assign p1If.riseClr = clrP1Rise;
  assign p1If.fallClr = clrP1Fall;

  // either edge of a pin counts as its event for the pin interrupts
  assign evtP0 = p0If.riseFlag | p0If.fallFlag;
  assign evtP1 = p1If.riseFlag | p1If.fallFlag;
  assign flagsAll = {evtP1, evtP0};
  assign portGate = {{PORT_W{r_q.port_pin_irq_enable[CTRL_P1_EN_BIT]}},
                     {PORT_W{r_q.port_pin_irq_enable[CTRL_P0_EN_BIT]}}};

  // one pin may feed both requests, and many pins may share one
  for (genvar i = 0; i < 2*PORT_W; i++) begin : g_pin
    assign srcA[i] = flagsAll[i] & portGate[i] & r_q.pin_to_irq_a_assign[i];
    assign srcB[i] = flagsAll[i] & portGate[i] & r_q.pin_to_irq_b_assign[i];
  end
  assign reqA = |srcA;
  assign reqB = |srcB;

  always_comb begin
    rdWord = RDATA_ZERO;
    unique case (regIdx)
      IDX_P0_RISE: begin
        rdWord[PORT_W-1:0] = p0If.riseFlag;
      end
      IDX_P0_FALL: begin
        rdWord[PORT_W-1:0] = p0If.fallFlag;
      end
      IDX_P1_RISE: begin
        rdWord[PORT_W-1:0] = p1If.riseFlag;
      end
      IDX_P1_FALL: begin
        rdWord[PORT_W-1:0] = p1If.fallFlag;
      end
      IDX_IRQ_CTRL: begin
        rdWord[CTRL_P1_EN_BIT:CTRL_P0_EN_BIT] = r_q.port_pin_irq_enable;
      end
      IDX_ASSIGN_A: begin
        rdWord[2*PORT_W-1:0] = r_q.pin_to_irq_a_assign;
      end
      IDX_ASSIGN_B: begin
        rdWord[2*PORT_W-1:0] = r_q.pin_to_irq_b_assign;
      end
      default: begin
        rdWord = RDATA_ZERO;
      end
    endcase
  end

  always_comb begin
    r_d = r_q;
    r_d.irqA = reqA;
    r_d.irqB = reqB;
    // the answer is prepared in setup and stands for the first access cycle
    r_d.ready = setupPh;
    r_d.err = setupPh & refused;
    r_d.rdata = RDATA_ZERO;
    if (setupPh && !pwrite && !refused) begin
      r_d.rdata = rdWord;
    end
    if (wrP0Rise) begin
      r_d.p0_rise_arm = wByte;
    end
    if (wrP0Fall) begin
      r_d.p0_fall_arm = wByte;
    end
    if (wrP1Rise) begin
      r_d.p1_rise_arm = wByte;
    end
    if (wrP1Fall) begin
      r_d.p1_fall_arm = wByte;
    end
    if (wrIrqCtrl) begin
      r_d.port_pin_irq_enable = wCtrl;
    end
    if (wrAssignA) begin
      r_d.pin_to_irq_a_assign = wAssign;
    end
    if (wrAssignB) begin
      r_d.pin_to_irq_b_assign = wAssign;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.rdata;
  assign pready = r_q.ready;
  assign pslverr = r_q.err;
  assign pin_irq_a = r_q.irqA;
  assign pin_irq_b = r_q.irqB;
endmodule

// file: ged_pin_model.sv
// pin driver model: applies a requested pin pattern after a chosen lag
`timescale 1ns/1ps
module ged_pin_model (
  input  wire logic        clk,
  input  wire logic [15:0] want,
  input  wire logic [3:0]  lag,
  output logic      [15:0] pins
);
  logic [3:0] cnt = 4'h0;
  initial pins = 16'h0000;
  // pins are asynchronous, so they move on the falling edge
  always @(negedge clk) begin
    if (want == pins) cnt <= 4'h0;
    else if (cnt >= lag) pins <= want;
    else cnt <= cnt + 4'h1;
  end
endmodule

// file: ged_edge_top_asserts.sv
// checker: apb answer timing and irq release of the edge latch top
`timescale 1ns/1ps
module ged_edge_top_asserts
  import ged_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pin_irq_a,
  input wire logic        pin_irq_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic su;
  logic wr;
  logic mapIdx;
  assign su = psel && !penable;
  assign wr = psel && pwrite;
  assign mapIdx = (paddr[1:0] == 2'h0) && (paddr[17:2] inside {IDX_P0_RISE, IDX_P1_RISE, IDX_P0_FALL, IDX_P1_FALL,
                                                               IDX_IRQ_CTRL, IDX_ASSIGN_A, IDX_ASSIGN_B});
  a_ready_after_setup: assert property (su |=> pready)
    else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("long ready");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("stray err");
  a_misalign_refused: assert property (su && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0)
    else $error("misalign");
  a_unmapped_refused: assert property (su && paddr[17:2] == 16'h0 |=> pslverr)
    else $error("unmapped");
  a_mapped_accepted: assert property (su && mapIdx |=> !pslverr)
    else $error("mapped err");
  a_read_upper_zero: assert property (su && !pwrite && paddr[17:2] == IDX_P1_FALL |=> prdata[31:8] == 24'h0)
    else $error("upper bits");
  a_irq_release_write: assert property ($fell(pin_irq_a) |-> $past(wr) || $past(wr, 2))
    else $error("irq drop");
  c_refused: cover property (pslverr);
  c_irq_a: cover property ($rose(pin_irq_a));
  c_irq_b: cover property ($rose(pin_irq_b));
endmodule
bind ged_edge_top ged_edge_top_asserts i_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .pin_irq_a, .pin_irq_b);

// file: ged_edge_top_tb_top.sv
// testbench: apb traffic, pin edges and queued read checks
`timescale 1ns/1ps
module ged_edge_top_tb_top;
  import ged_pkg::*;
  logic        clk, pready, pslverr, irqA, irqB;
  logic        rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'd42883;
  logic [15:0] want = 16'h0, pins, prv = 16'h0;
  logic [3:0]  lag = 4'h0;
  logic [1:0]  en = 2'h3;
  logic [15:0] asA = 16'h00FF, asB = 16'hFF00, src;
  logic [7:0]  arm[4], fl[4] = '{default: 8'h00};
  logic [32:0] q[$], ex;
  int          mismatches = 0, checksDone = 0;
  logic [17:0] ad[4] = '{{IDX_P0_RISE, 2'b00}, {IDX_P1_RISE, 2'b00}, {IDX_P0_FALL, 2'b00}, {IDX_P1_FALL, 2'b00}};
  ged_edge_top i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .port0Pin(pins[7:0]), .port1Pin(pins[15:8]), .pin_irq_a(irqA), .pin_irq_b(irqB));
  ged_pin_model i_pins (.clk, .want, .lag, .pins);
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic completeRun;
    $display("checks=%0d mismatches=%0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // a free edge before each setup keeps psel from being written twice in one step
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge clk);
    q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    apb(1'b1, ad[k], {24'h0, d}, 33'h0);
    arm[k] = d;
    fl[k] &= d;
  endtask
  task automatic drive(input logic [15:0] v);
    logic [7:0] o, n;
    want <= v;
    lag <= seed[3:0];
    repeat (24) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      o = prv[k[0]*8 +: 8];
      n = v[k[0]*8 +: 8];
      fl[k] |= arm[k] & ((k < 2) ? (n & ~o) : (o & ~n));
    end
    prv = v;
    @(negedge clk);
    src = {fl[1] | fl[3], fl[0] | fl[2]} & {{8{en[1]}}, {8{en[0]}}};
    chk(32'(irqA), 32'(|(src & asA)));
    chk(32'(irqB), 32'(|(src & asB)));
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      ex = q.pop_front();
      chk(32'(pslverr), 32'(ex[32]));
      if (!pwrite) chk(prdata, ex[31:0]);
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    mismatches++;
    completeRun();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) apb(1'b0, ad[k], 32'h0, 33'h0);
    apb(1'b0, 18'h00000, 32'h0, {1'b1, 32'h0});
    apb(1'b0, 18'h280A1, 32'h0, {1'b1, 32'h0});
    apb(1'b1, {IDX_IRQ_CTRL, 2'b00}, 32'h3, 33'h0);
    apb(1'b1, {IDX_ASSIGN_A, 2'b00}, 32'h00FF, 33'h0);
    apb(1'b1, {IDX_ASSIGN_B, 2'b00}, 32'hFF00, 33'h0);
    for (int r = 0; r < 7; r++) begin
      if (r == 3) begin
        en = 2'h1;
        asB = 16'hFFFF;
        apb(1'b1, {IDX_IRQ_CTRL, 2'b00}, {30'h0, en}, 33'h0);
        apb(1'b1, {IDX_ASSIGN_B, 2'b00}, {16'h0, asB}, 33'h0);
        apb(1'b0, {IDX_IRQ_CTRL, 2'b00}, 32'h0, {31'h0, en});
        apb(1'b0, {IDX_ASSIGN_B, 2'b00}, 32'h0, {17'h0, asB});
      end
      seed = xorshift(seed);
      for (int k = 0; k < 4; k++) wr(k, (r == 0) ? 8'hFF : (r == 6) ? 8'h00 : seed[k*8 +: 8]);
      for (int k = 0; k < 4; k++) apb(1'b0, ad[k], 32'h0, {25'h0, fl[k]});
      drive(seed[15:0]);
      seed = xorshift(seed);
      drive(seed[31:16]);
      for (int k = 0; k < 4; k++) apb(1'b0, ad[k], 32'h0, {25'h0, fl[k]});
    end
    completeRun();
  end
endmodule
